/* File: logic/fcr_config_regs.sv */
// Contract
// - Index register: bits 2..0 RW, rest zero
// - Index tells controller loaded parameter count
// - Protection status register is read only
// - Bit 7 shows protection override active
// - Config bits 7,4,1,0 RW, bit 5 read only, others zero
// - Complete interrupt when enable and flag set
// - Erase-all bit never changed by writes
// - Erase-all bit sets on request, flag high
// - Erase, verify, program byte, then unsecure
// - Erase-all bit clears when operation done
// - Ignore bit suppresses single fault reporting
// - Forced double fault flags every read
// - Else double flag only on real fault
// - Forced double bit stays until cleared
// - Forced single fault flags every read while ignore bit clear
// - Else single flag only on real fault
// - Forced single bit stays until cleared
// - Writing 1 launches; flag low until done
// - Single fault interrupt when enabled and flagged
// - Unsecure security encoding is binary 10
`default_nettype none
module fcr_config_regs
   import fcr_pkg::*;
(
   input  wire logic            sys_clk_in,
   input  wire logic            rstn_in,
   input  wire fcr_bus_req_s    bus_req_in,
   output logic [7:0]           bus_rdata_out,
   input  wire logic            erase_all_req_in,
   input  wire logic            prot_override_in,
   input  wire fcr_array_read_s array_read_in,
   input  wire logic            cmd_done_in,
   input  wire logic            cmd_violation_in,
   input  wire logic            erase_step_done_in,
   output logic                 cmd_launch_out,
   output logic [2:0]           param_word_index_out,
   output logic [1:0]           erase_step_out,
   output logic                 erase_busy_out,
   output logic                 cc_irq_out,
   output logic                 sf_irq_out,
   output logic                 df_irq_out
);
   typedef enum logic [2:0] {ES_IDLE, ES_ERASE, ES_VERIFY, ES_PROGRAM, ES_UNSECURE} fcr_erase_e;

   logic [2:0] pidx_q;
   logic [7:0] cfg_q;
   logic       cc_flag_q;
   logic [1:0] err_q;
   logic [1:0] err_cfg_q;
   logic [7:0] sec_q;
   fcr_erase_e es_q;
   logic       wr_cfg, wr_stat, wr_err, launch, erase_go, erase_last;
   logic [1:0] flt_hit;

   assign wr_cfg  = bus_req_in.wr && bus_req_in.addr == CONFIG_OFS;
   assign wr_stat = bus_req_in.wr && bus_req_in.addr == CMD_STATUS_OFS;
   assign wr_err  = bus_req_in.wr && bus_req_in.addr == ERROR_STATUS_OFS;
   assign erase_go   = es_q == ES_IDLE && erase_all_req_in && cc_flag_q;
   assign erase_last = es_q == ES_UNSECURE && erase_step_done_in;
   // Launch refused while erase-all runs or a command is in flight; an erase
   // start in the same cycle wins so only one sequence owns the array
   assign launch  = wr_stat && bus_req_in.wdata[CSTAT_CC_FLAG_BIT] && cc_flag_q
                    && es_q == ES_IDLE && !erase_go;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         pidx_q <= PIDX_RESET;
      end else if (bus_req_in.wr && bus_req_in.addr == CMD_PARAM_INDEX_OFS) begin
         pidx_q <= bus_req_in.wdata[PIDX_W-1:0];
      end
   end
   assign param_word_index_out = pidx_q;

   // Config: erase bit written only by the sequencer
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cfg_q <= CFG_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_q[CFG_CC_IRQ_EN_BIT] <= bus_req_in.wdata[CFG_CC_IRQ_EN_BIT];
            cfg_q[CFG_IGN_SF_BIT]    <= bus_req_in.wdata[CFG_IGN_SF_BIT];
            cfg_q[CFG_FORCE_DF_BIT]  <= bus_req_in.wdata[CFG_FORCE_DF_BIT];
            cfg_q[CFG_FORCE_SF_BIT]  <= bus_req_in.wdata[CFG_FORCE_SF_BIT];
         end
         if (erase_go) begin
            cfg_q[CFG_ERASE_REQ_BIT] <= 1'b1;
         end else if (erase_last) begin
            cfg_q[CFG_ERASE_REQ_BIT] <= 1'b0;
         end
      end
   end

   // Erase-all sequencer, each step acknowledged by the array engine
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         es_q <= ES_IDLE;
      end else begin
         case (es_q)
            ES_IDLE:     if (erase_go) es_q <= ES_ERASE;
            ES_ERASE:    if (erase_step_done_in) es_q <= ES_VERIFY;
            ES_VERIFY:   if (erase_step_done_in) es_q <= ES_PROGRAM;
            ES_PROGRAM:  if (erase_step_done_in) es_q <= ES_UNSECURE;
            ES_UNSECURE: if (erase_step_done_in) es_q <= ES_IDLE;
            default:     es_q <= ES_IDLE;
         endcase
      end
   end
   assign erase_busy_out = es_q != ES_IDLE;
   always_comb begin
      case (es_q)
         ES_VERIFY:   erase_step_out = 2'h1;
         ES_PROGRAM:  erase_step_out = 2'h2;
         ES_UNSECURE: erase_step_out = 2'h3;
         default:     erase_step_out = 2'h0;
      endcase
   end

   // Security state; only the unsecure field value is touched here
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         sec_q <= SEC_RESET;
      end else if (erase_last) begin
         sec_q[1:0] <= SEC_UNSECURE;
      end
   end

   // Command complete flag; erase-all also holds it low
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cc_flag_q <= 1'b1;
      end else if (launch || erase_go) begin
         cc_flag_q <= 1'b0;
      end else if ((cmd_done_in || cmd_violation_in) && es_q == ES_IDLE) begin
         cc_flag_q <= 1'b1;
      end else if (erase_last) begin
         cc_flag_q <= 1'b1;
      end
   end
   assign cmd_launch_out = launch;

   // Fault flags: hardware set wins over write-1 clear
   assign flt_hit[ERR_SF_BIT] = array_read_in.valid && !cfg_q[CFG_IGN_SF_BIT] &&
      (cfg_q[CFG_FORCE_SF_BIT] || array_read_in.fault == RD_SINGLE);
   assign flt_hit[ERR_DF_BIT] = array_read_in.valid &&
      (cfg_q[CFG_FORCE_DF_BIT] || array_read_in.fault == RD_DOUBLE);
   for (genvar gi = 0; gi < 2; gi++) begin : g_flt
      always_ff @(posedge sys_clk_in) begin
         if (!rstn_in) begin
            err_q[gi] <= 1'b0;
         end else if (flt_hit[gi]) begin
            err_q[gi] <= 1'b1;
         end else if (wr_err && bus_req_in.wdata[gi]) begin
            err_q[gi] <= 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         err_cfg_q <= 2'h0;
      end else if (bus_req_in.wr && bus_req_in.addr == ERROR_CONFIG_OFS) begin
         err_cfg_q <= bus_req_in.wdata[1:0];
      end
   end

   assign cc_irq_out = cfg_q[CFG_CC_IRQ_EN_BIT] && cc_flag_q;
   assign sf_irq_out = err_cfg_q[ERR_SF_BIT] && err_q[ERR_SF_BIT];
   assign df_irq_out = err_cfg_q[ERR_DF_BIT] && err_q[ERR_DF_BIT];

   // Read data valid one cycle after the strobe only
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in || !bus_req_in.rd) begin
         bus_rdata_out <= 8'h00;
      end else if (bus_req_in.addr == CMD_PARAM_INDEX_OFS) begin
         bus_rdata_out <= {5'h00, pidx_q};
      end else if (bus_req_in.addr == PROT_STATUS_OFS) begin
         bus_rdata_out <= {prot_override_in, 7'h00};
      end else if (bus_req_in.addr == CONFIG_OFS) begin
         bus_rdata_out <= cfg_q & (CFG_RW_MASK | 8'h20);
      end else if (bus_req_in.addr == CMD_STATUS_OFS) begin
         bus_rdata_out <= {cc_flag_q, 7'h00};
      end else if (bus_req_in.addr == ERROR_STATUS_OFS) begin
         bus_rdata_out <= {6'h00, err_q};
      end else if (bus_req_in.addr == ERROR_CONFIG_OFS) begin
         bus_rdata_out <= {6'h00, err_cfg_q};
      end else if (bus_req_in.addr == SECURITY_OFS) begin
         bus_rdata_out <= sec_q;
      end else begin
         bus_rdata_out <= 8'h00;
      end
   end
endmodule // fcr_config_regs
`default_nettype wire

/* File: logic/fcr_pkg.sv */
`default_nettype none
package fcr_pkg;
   // Register word offsets on the plain register port
   localparam logic [3:0] CMD_PARAM_INDEX_OFS   = 4'h0;
   localparam logic [3:0] PROT_STATUS_OFS       = 4'h1;
   localparam logic [3:0] CONFIG_OFS            = 4'h2;
   localparam logic [3:0] CMD_STATUS_OFS        = 4'h3;
   localparam logic [3:0] ERROR_STATUS_OFS      = 4'h4;
   localparam logic [3:0] ERROR_CONFIG_OFS      = 4'h5;
   localparam logic [3:0] SECURITY_OFS          = 4'h6;

   // Configuration register fields
   localparam int CFG_CC_IRQ_EN_BIT   = 7;
   localparam int CFG_ERASE_REQ_BIT   = 5;
   localparam int CFG_IGN_SF_BIT      = 4;
   localparam int CFG_FORCE_DF_BIT    = 1;
   localparam int CFG_FORCE_SF_BIT    = 0;
   localparam logic [7:0] CFG_RW_MASK = 8'h93;

   // Other fields
   localparam int PSTAT_OVRD_BIT      = 7;
   localparam int CSTAT_CC_FLAG_BIT   = 7;
   localparam int ERR_DF_BIT          = 1;
   localparam int ERR_SF_BIT          = 0;
   localparam int PIDX_W              = 3;
   localparam logic [1:0] SEC_UNSECURE = 2'h2;

   // Reset values
   localparam logic [7:0] CFG_RESET    = 8'h00;
   localparam logic [2:0] PIDX_RESET   = 3'h0;
   localparam logic [7:0] SEC_RESET    = 8'h01;

   typedef enum logic [1:0] {RD_NONE, RD_SINGLE, RD_DOUBLE} fcr_fault_e;

   typedef struct packed {
      logic       valid;
      fcr_fault_e fault;
   } fcr_array_read_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } fcr_bus_req_s;
endpackage : fcr_pkg
`default_nettype wire

/* File: verif/fcr_config_regs_assertions.sv */
`default_nettype none
module fcr_config_regs_chk
   import fcr_pkg::*;
(
   input wire logic         sys_clk_in,
   input wire logic         rstn_in,
   input wire fcr_bus_req_s bus_req_in,
   input wire logic [7:0]   bus_rdata_out,
   input wire logic         prot_override_in,
   input wire logic         erase_step_done_in,
   input wire logic         cmd_launch_out,
   input wire logic [2:0]   param_word_index_out,
   input wire logic [1:0]   erase_step_out,
   input wire logic         erase_busy_out,
   input wire logic         cc_irq_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_adv;
      erase_busy_out && erase_step_done_in;
   endsequence
   sequence s_rd(logic [3:0] a);
      bus_req_in.rd && bus_req_in.addr == a;
   endsequence
   a_erase_start: assert property ($rose(erase_busy_out) |-> erase_step_out == 2'h0)
      else $error("erase did not start with block erase");
   a_step_order: assert property (s_adv ##0 erase_step_out != 2'h3
      |=> erase_step_out == $past(erase_step_out) + 2'h1) else $error("erase step skipped");
   a_erase_end: assert property (s_adv ##0 erase_step_out == 2'h3 |=> !erase_busy_out)
      else $error("erase sequence did not finish");
   a_launch_flag: assert property (cmd_launch_out |=> !cc_irq_out)
      else $error("complete request stayed after launch");
   a_irq_off: assert property (bus_req_in.wr && bus_req_in.addr == CONFIG_OFS
      && !bus_req_in.wdata[CFG_CC_IRQ_EN_BIT] |=> !cc_irq_out)
      else $error("complete request while disabled");
   a_idx_write: assert property (bus_req_in.wr && bus_req_in.addr == CMD_PARAM_INDEX_OFS
      |=> param_word_index_out == $past(bus_req_in.wdata[2:0])) else $error("index not written");
   a_idx_read: assert property (s_rd(CMD_PARAM_INDEX_OFS)
      |=> bus_rdata_out == {5'h00, param_word_index_out}) else $error("index read wrong");
   a_cfg_zero: assert property (s_rd(CONFIG_OFS) |=> (bus_rdata_out & 8'h4C) == 8'h00)
      else $error("unassigned config bits set");
   a_prot_read: assert property (s_rd(PROT_STATUS_OFS)
      |=> bus_rdata_out[7] == $past(prot_override_in)) else $error("override status wrong");
   a_launch_idle: assert property (cmd_launch_out |-> !erase_busy_out)
      else $error("launch accepted during erase-all");
endmodule // fcr_config_regs_chk
bind fcr_config_regs fcr_config_regs_chk fcr_config_regs_chk_i (
   .sys_clk_in           (sys_clk_in),
   .rstn_in              (rstn_in),
   .bus_req_in           (bus_req_in),
   .bus_rdata_out        (bus_rdata_out),
   .prot_override_in     (prot_override_in),
   .erase_step_done_in   (erase_step_done_in),
   .cmd_launch_out       (cmd_launch_out),
   .param_word_index_out (param_word_index_out),
   .erase_step_out       (erase_step_out),
   .erase_busy_out       (erase_busy_out),
   .cc_irq_out           (cc_irq_out)
);
`default_nettype wire

/* File: verif/fcr_config_regs_test.sv */
`default_nettype none
module fcr_config_regs_test
   import fcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in, rstn_in, erase_all_req_in, prot_override_in;
   logic cmd_done_in, cmd_violation_in, erase_step_done_in;
   logic cmd_launch_out, erase_busy_out, cc_irq_out, sf_irq_out, df_irq_out;
   fcr_bus_req_s    bus_req_in;
   fcr_array_read_s array_read_in;
   logic [7:0]      bus_rdata_out;
   logic [2:0]      param_word_index_out;
   logic [1:0]      erase_step_out;
   int              n_fail, checked;
   fcr_config_regs fcr_config_regs_i (
      .sys_clk_in           (sys_clk_in),
      .rstn_in              (rstn_in),
      .bus_req_in           (bus_req_in),
      .bus_rdata_out        (bus_rdata_out),
      .erase_all_req_in     (erase_all_req_in),
      .prot_override_in     (prot_override_in),
      .array_read_in        (array_read_in),
      .cmd_done_in          (cmd_done_in),
      .cmd_violation_in     (cmd_violation_in),
      .erase_step_done_in   (erase_step_done_in),
      .cmd_launch_out       (cmd_launch_out),
      .param_word_index_out (param_word_index_out),
      .erase_step_out       (erase_step_out),
      .erase_busy_out       (erase_busy_out),
      .cc_irq_out           (cc_irq_out),
      .sf_irq_out           (sf_irq_out),
      .df_irq_out           (df_irq_out)
   );
   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in) bus_req_in <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk_in) bus_req_in <= '0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge sys_clk_in) bus_req_in <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk_in) bus_req_in <= '0;
      #1 chk(n, bus_rdata_out, e);
   endtask
   // Pulse order: done, violation, step done, erase request
   task automatic pulse(input logic [3:0] p, input fcr_array_read_s r);
      @(posedge sys_clk_in) {cmd_done_in, cmd_violation_in, erase_step_done_in,
         erase_all_req_in} <= p;
      array_read_in <= r;
      @(posedge sys_clk_in) {cmd_done_in, cmd_violation_in, erase_step_done_in,
         erase_all_req_in} <= 4'h0;
      array_read_in <= '0;
      #1;
   endtask
   task automatic irqs(input logic [7:0] e);
      chk("irqs", {5'h00, cc_irq_out, sf_irq_out, df_irq_out}, e);
   endtask
   task automatic t_regs();
      rd(CONFIG_OFS, 8'h00, "cfg reset");
      rd(CMD_PARAM_INDEX_OFS, 8'h00, "idx reset");
      wr(CMD_PARAM_INDEX_OFS, 8'hFF);
      rd(CMD_PARAM_INDEX_OFS, 8'h07, "idx");
      chk("idx out", {5'h00, param_word_index_out}, 8'h07);
      wr(CONFIG_OFS, 8'hFF);
      rd(CONFIG_OFS, 8'h93, "cfg");
      wr(PROT_STATUS_OFS, 8'hFF);
      rd(PROT_STATUS_OFS, 8'h00, "prot");
      @(posedge sys_clk_in) prot_override_in <= 1'b1;
      rd(PROT_STATUS_OFS, 8'h80, "prot ovrd");
      rd(4'hF, 8'h00, "unmapped");
      wr(CONFIG_OFS, 8'h00);
      $display("done regs");
   endtask
   task automatic t_irq();
      irqs(8'h00);
      wr(CONFIG_OFS, 8'h80);
      irqs(8'h04);
      wr(CMD_STATUS_OFS, 8'h80);
      irqs(8'h00);
      pulse(4'h8, '0);
      irqs(8'h04);
      wr(CMD_STATUS_OFS, 8'h80);
      pulse(4'h4, '0);
      irqs(8'h04);
      wr(CONFIG_OFS, 8'h00);
      irqs(8'h00);
      $display("done irq");
   endtask
   task automatic t_fault();
      wr(ERROR_CONFIG_OFS, 8'h03);
      wr(CONFIG_OFS, 8'h03);
      pulse(4'h0, '{1'b1, RD_NONE});
      irqs(8'h03);
      wr(ERROR_STATUS_OFS, 8'h03);
      rd(CONFIG_OFS, 8'h03, "force held");
      wr(CONFIG_OFS, 8'h00);
      pulse(4'h0, '{1'b1, RD_NONE});
      irqs(8'h00);
      pulse(4'h0, '{1'b1, RD_SINGLE});
      irqs(8'h02);
      wr(ERROR_STATUS_OFS, 8'h01);
      wr(CONFIG_OFS, 8'h10);
      pulse(4'h0, '{1'b1, RD_SINGLE});
      irqs(8'h00);
      pulse(4'h0, '{1'b1, RD_DOUBLE});
      irqs(8'h01);
      wr(ERROR_STATUS_OFS, 8'h03);
      wr(CONFIG_OFS, 8'h00);
      $display("done fault");
   endtask
   task automatic t_erase();
      pulse(4'h1, '0);
      rd(CONFIG_OFS, 8'h20, "erase set");
      wr(CONFIG_OFS, 8'h00);
      rd(CONFIG_OFS, 8'h20, "erase kept");
      chk("busy", {7'h00, erase_busy_out}, 8'h01);
      wr(CMD_STATUS_OFS, 8'h80);
      pulse(4'h8, '0);
      rd(CMD_STATUS_OFS, 8'h00, "flag low in erase");
      for (int i = 0; i < 4; i++) begin
         chk("step", {6'h00, erase_step_out}, 8'(i));
         pulse(4'h2, '0);
      end
      chk("idle", {7'h00, erase_busy_out}, 8'h00);
      rd(CONFIG_OFS, 8'h00, "erase clr");
      rd(CMD_STATUS_OFS, 8'h80, "flag back");
      rd(SECURITY_OFS, 8'h02, "unsecure");
      wr(CMD_STATUS_OFS, 8'h80);
      pulse(4'h1, '0);
      rd(CONFIG_OFS, 8'h00, "erase refused");
      chk("no start", {7'h00, erase_busy_out}, 8'h00);
      pulse(4'h8, '0);
      rd(CMD_STATUS_OFS, 8'h80, "flag done");
      $display("done erase");
   endtask
   task automatic final_report();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      {rstn_in, erase_all_req_in, prot_override_in, cmd_done_in} = 4'h0;
      {cmd_violation_in, erase_step_done_in} = 2'h0;
      bus_req_in = '0;
      array_read_in = '0;
      n_fail = 0;
      checked = 0;
      repeat (4) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      t_regs();
      t_irq();
      t_fault();
      t_erase();
      final_report();
   end
   // Whole run is about a hundred cycles
   initial begin
      #20000;
      n_fail++;
      final_report();
   end
endmodule // fcr_config_regs_test
`default_nettype wire
